// ---- core/ews_ctrl.sv ----
`timescale 1ns/1ps
// Summary of operation
// RULE1 - Eight external request channels, each with its own detection condition.
// RULE2 - Plain interrupt channels detect high level, low level, rising or falling edge.
// RULE3 - Channels serving data transfer offer only high or low level detection.
// RULE4 - Each external request reaches the CPU only when its enable bit is set.
// RULE5 - A detected external request is latched in a flag until serviced or cleared.
// RULE6 - Service select 0: an accepted request goes straight to the handler.
// RULE7 - Service select 1: automatic transfer first, handler only after it completes.
// RULE8 - Eight wakeup inputs, each requesting on a low level at its pin.
// RULE9 - All wakeup channels set one common wakeup flag.
// RULE10 - Wakeup requests pass to the CPU only when enabled in wakeup control.
// RULE11 - The pending wakeup request is held in a software-readable flag register.
// RULE12 - Enabled wakeup ends standby, but never hardware standby.
// RULE13 - Wakeup requests never start automatic transfer; they are plain interrupts.
// RULE14 - Writing 1 to the delayed request bit raises the delayed request.
// RULE15 - Writing 0 to the delayed request bit withdraws the delayed request.
// RULE16 - The delayed request has no enable; the bit alone drives it.
// RULE17 - The delayed request state reads back from the delayed request bit.
// RULE18 - Pin inputs pass a two-stage synchroniser before any detection.
// RULE19 - A cleared level-detected flag sets again while the active level persists.
module ews_ctrl (
	input  wire logic                                i_clock,
	input  wire logic                                i_rst,
	input  wire logic                                i_wb_cyc,
	input  wire logic                                i_wb_stb,
	input  wire logic                                i_wb_we,
	input  wire logic [ews_pkg::WB_ADDR_W-1:0]       i_wb_adr,
	input  wire logic [3:0]                          i_wb_sel,
	input  wire logic [31:0]                         i_wb_dat,
	output logic      [31:0]                         o_wb_dat,
	output logic                                     o_wb_ack,
	input  wire logic [ews_pkg::EXT_CHANNELS-1:0]    i_ext_req_in,
	input  wire logic [ews_pkg::WAKE_CHANNELS-1:0]   i_wake_in_n,
	input  wire logic [ews_pkg::EXT_CHANNELS-1:0]    i_xfer_done,
	input  wire logic                                i_standby,
	input  wire logic                                i_hw_standby,
	output ews_pkg::ews_req_t                        o_req,
	output logic                                     o_irq
);
	import ews_pkg::*;

	logic [EXT_CHANNELS-1:0]  ext_meta_r;
	logic [EXT_CHANNELS-1:0]  ext_sync_r;
	logic [EXT_CHANNELS-1:0]  ext_prev_r;
	logic [WAKE_CHANNELS-1:0] wake_meta_r;
	logic [WAKE_CHANNELS-1:0] wake_sync_r;

	logic [15:0]              detect_level_cfg_r;
	logic [EXT_CHANNELS-1:0]  ext_req_enable_r;
	logic [EXT_CHANNELS-1:0]  ext_req_flags_r;
	logic [EXT_CHANNELS-1:0]  auto_xfer_select_r;
	logic [EXT_CHANNELS-1:0]  xfer_done_r;
	logic [WAKE_CHANNELS-1:0] wake_enable_ctrl_r;
	logic                     wake_flag_r;
	logic                     delayed_req_bit_r;
	logic [EVT_W-1:0]         irq_status_r;
	logic [EVT_W-1:0]         irq_mask_r;

	logic [EXT_CHANNELS-1:0]  ext_detect;
	logic                     wake_detect;
	logic [EXT_CHANNELS-1:0]  ext_irq_nxt;
	logic [EXT_CHANNELS-1:0]  xfer_req_nxt;
	logic [EVT_W-1:0]         evt;

	logic                     wr_stb;
	logic                     wr_cfg;
	logic                     wr_enable;
	logic                     wr_select;
	logic                     wr_wake_en;
	logic                     wr_irq_mask;
	logic                     wr_flags;
	logic                     wr_wake_flag;
	logic                     wr_delayed;
	logic                     wr_status;
	logic [1:0]               fill_cnt_r;
	logic                     edge_ok;
	logic [31:0]              wr_mask;
	logic [31:0]              rd_nxt;

	ews_req_t                 req_r;
	logic                     irq_r;

	// Pins are asynchronous; the second stage, and the third (ext_prev_r) for edges, feed detection.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ext_meta_r <= '0;
			ext_sync_r <= '0;
			ext_prev_r <= '0;
		end else begin
			ext_meta_r <= i_ext_req_in;  // see RULE18
			ext_sync_r <= ext_meta_r;
			ext_prev_r <= ext_sync_r;
		end
	end

	// Wakeup pins idle high, so their stages reset to the inactive level.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			wake_meta_r <= '1;
			wake_sync_r <= '1;
		end else begin
			wake_meta_r <= i_wake_in_n;  // see RULE18
			wake_sync_r <= wake_meta_r;
		end
	end

	// The edge history holds no real pin sample until a few edges after reset.
	// Edge detection waits for it, so that an idle-high pin gives no false edge.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			fill_cnt_r <= '0;
		end else if (fill_cnt_r != EDGE_FILL_CYCLES) begin
			fill_cnt_r <= fill_cnt_r + 2'h1;
		end
	end

	assign edge_ok = (fill_cnt_r == EDGE_FILL_CYCLES);

	// Per-channel detection of the programmed condition.
	generate
		for (genvar ch = 0; ch < EXT_CHANNELS; ch++) begin : g_detect
			ews_det_t mode;
			always_comb begin
				mode = ews_det_t'(detect_level_cfg_r[2*ch +: 2]);  // see RULE1
				// A transfer channel accepts only levels: rise acts as high, fall as low.
				if (auto_xfer_select_r[ch] && mode[1]) begin
					mode = mode[0] ? EWS_DET_LOW : EWS_DET_HIGH;  // see RULE3
				end
				case (mode)
					EWS_DET_LOW:  ext_detect[ch] = ~ext_sync_r[ch];  // see RULE2
					EWS_DET_HIGH: ext_detect[ch] = ext_sync_r[ch];
					EWS_DET_RISE: ext_detect[ch] = edge_ok & ext_sync_r[ch] & ~ext_prev_r[ch];
					EWS_DET_FALL: ext_detect[ch] = edge_ok & ~ext_sync_r[ch] & ext_prev_r[ch];
					default:      ext_detect[ch] = 1'b0;
				endcase
			end
		end
	endgenerate

	assign wake_detect = |(~wake_sync_r & wake_enable_ctrl_r);  // see RULE8, see RULE9

	// Handler request waits for a completed transfer on transfer channels.
	assign ext_irq_nxt  = ext_req_flags_r & ext_req_enable_r
		& (~auto_xfer_select_r | xfer_done_r);                 // see RULE4, see RULE6
	assign xfer_req_nxt = ext_req_flags_r & ext_req_enable_r
		& auto_xfer_select_r & ~xfer_done_r;                   // see RULE7

	// Wishbone classic slave: ack follows one cycle after the request is seen
	// and stands for one cycle. A write lands at the edge where the master
	// samples ack high, the one edge at which master and slave agree that the
	// transfer happens.
	assign wr_stb = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack;

	// Per-register write strobes.
	assign wr_cfg       = wr_stb & (i_wb_adr == DETECT_LEVEL_CFG_OFF);
	assign wr_enable    = wr_stb & (i_wb_adr == EXT_REQ_ENABLE_OFF) & i_wb_sel[0];
	assign wr_select    = wr_stb & (i_wb_adr == AUTO_XFER_SELECT_OFF) & i_wb_sel[0];
	assign wr_wake_en   = wr_stb & (i_wb_adr == WAKE_ENABLE_CTRL_OFF) & i_wb_sel[0];
	assign wr_irq_mask  = wr_stb & (i_wb_adr == IRQ_MASK_OFF) & i_wb_sel[0];
	assign wr_flags     = wr_stb & (i_wb_adr == EXT_REQ_FLAGS_OFF) & i_wb_sel[0];
	assign wr_wake_flag = wr_stb & (i_wb_adr == WAKE_FLAG_REG_OFF) & i_wb_sel[0];
	assign wr_delayed   = wr_stb & (i_wb_adr == DELAYED_REQ_REG_OFF) & i_wb_sel[0];
	assign wr_status    = wr_stb & (i_wb_adr == IRQ_STATUS_OFF) & i_wb_sel[0];

	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wr_mask[8*b +: 8] = {8{i_wb_sel[b]}};
		end
	end

	// Detection codes, written byte lane by byte lane.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			detect_level_cfg_r <= DETECT_LEVEL_CFG_RST;
		end else if (wr_cfg) begin
			detect_level_cfg_r <= (detect_level_cfg_r & ~wr_mask[15:0])
				| (i_wb_dat[15:0] & wr_mask[15:0]);
		end
	end

	// Per-channel request enables.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ext_req_enable_r <= EXT_REQ_ENABLE_RST;
		end else if (wr_enable) begin
			ext_req_enable_r <= i_wb_dat[7:0];
		end
	end

	// Per-channel choice between handler and automatic transfer.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			auto_xfer_select_r <= AUTO_XFER_SELECT_RST;
		end else if (wr_select) begin
			auto_xfer_select_r <= i_wb_dat[7:0];
		end
	end

	// Per-pin wakeup enables.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			wake_enable_ctrl_r <= WAKE_ENABLE_CTRL_RST;
		end else if (wr_wake_en) begin
			wake_enable_ctrl_r <= i_wb_dat[7:0];  // see RULE10
		end
	end

	// Interrupt mask, same layout as the status register.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			irq_mask_r <= IRQ_MASK_RST;
		end else if (wr_irq_mask) begin
			irq_mask_r <= i_wb_dat[EVT_W-1:0];
		end
	end

	// External flags: write one to clear, a new detection wins over the clear.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ext_req_flags_r <= '0;
		end else begin
			if (wr_flags) begin
				ext_req_flags_r <= (ext_req_flags_r & ~i_wb_dat[7:0])
					| ext_detect;                              // see RULE5, see RULE19
			end else begin
				ext_req_flags_r <= ext_req_flags_r | ext_detect;  // see RULE5
			end
		end
	end

	// Transfer completion per channel, forgotten once its flag is cleared.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			xfer_done_r <= '0;
		end else begin
			xfer_done_r <= (xfer_done_r | (i_xfer_done & req_r.xfer_req))
				& ext_req_flags_r;                             // see RULE7
		end
	end

	// Common wakeup flag, write one to clear, set wins.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			wake_flag_r <= 1'b0;
		end else if (wake_detect) begin
			wake_flag_r <= 1'b1;                               // see RULE9, see RULE11
		end else if (wr_wake_flag && i_wb_dat[WAKE_FLAG_POS]) begin
			wake_flag_r <= 1'b0;
		end
	end

	// Delayed request follows the written value of its bit.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			delayed_req_bit_r <= 1'b0;
		end else if (wr_delayed) begin
			delayed_req_bit_r <= i_wb_dat[DELAYED_REQ_BIT_POS];  // see RULE14, see RULE15
		end
	end

	// Rising edges of the handler, wakeup and delayed requests, and completed transfers, become sticky status events.
	always_comb begin
		evt = '0;
		evt[EVT_EXT_POS]     = |(ext_irq_nxt & ~req_r.ext_irq);
		evt[EVT_WAKE_POS]    = wake_flag_r & ~req_r.wake_irq;
		evt[EVT_DELAYED_POS] = delayed_req_bit_r & ~req_r.delayed_irq;
		evt[EVT_XFER_POS]    = |(i_xfer_done & req_r.xfer_req);
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			irq_status_r <= '0;
		end else if (wr_status) begin
			irq_status_r <= (irq_status_r & ~i_wb_dat[EVT_W-1:0]) | evt;
		end else begin
			irq_status_r <= irq_status_r | evt;
		end
	end

	// Registered request outputs.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			req_r <= '0;
		end else begin
			req_r.ext_irq     <= ext_irq_nxt;
			req_r.xfer_req    <= xfer_req_nxt;
			req_r.wake_irq    <= wake_flag_r;                        // see RULE13
			req_r.wake_resume <= wake_flag_r & i_standby & ~i_hw_standby;  // see RULE12
			req_r.delayed_irq <= delayed_req_bit_r;                 // see RULE16
		end
	end

	// Level interrupt, high while any unmasked status bit is set.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(irq_status_r & irq_mask_r);
		end
	end

	always_comb begin
		rd_nxt = '0;
		case (i_wb_adr)
			DETECT_LEVEL_CFG_OFF: rd_nxt[15:0] = detect_level_cfg_r;
			EXT_REQ_ENABLE_OFF:   rd_nxt[7:0] = ext_req_enable_r;
			EXT_REQ_FLAGS_OFF:    rd_nxt[7:0] = ext_req_flags_r;
			AUTO_XFER_SELECT_OFF: rd_nxt[7:0] = auto_xfer_select_r;
			WAKE_ENABLE_CTRL_OFF: rd_nxt[7:0] = wake_enable_ctrl_r;
			WAKE_FLAG_REG_OFF:    rd_nxt[WAKE_FLAG_POS] = wake_flag_r;
			DELAYED_REQ_REG_OFF:  rd_nxt[DELAYED_REQ_BIT_POS] = delayed_req_bit_r;  // see RULE17
			IRQ_STATUS_OFF:       rd_nxt[EVT_W-1:0] = irq_status_r;
			IRQ_MASK_OFF:         rd_nxt[EVT_W-1:0] = irq_mask_r;
			XFER_DONE_OFF:        rd_nxt[7:0] = xfer_done_r;
			default:              rd_nxt = '0;
		endcase
	end

	// Ack drops after one cycle even while the master still holds its request.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_wb_ack <= 1'b0;
		end else begin
			o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
		end
	end

	// Read data follows the address every cycle and is valid while ack stands.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_wb_dat <= '0;
		end else begin
			o_wb_dat <= rd_nxt;
		end
	end

	assign o_req = req_r;
	assign o_irq = irq_r;

endmodule : ews_ctrl

// ---- core/ews_pkg.sv ----
package ews_pkg;

	localparam int EXT_CHANNELS = 8;
	localparam int WAKE_CHANNELS = 8;
	localparam int WB_ADDR_W = 8;

	// Register byte offsets.
	localparam logic [WB_ADDR_W-1:0] DETECT_LEVEL_CFG_OFF = 8'h00;
	localparam logic [WB_ADDR_W-1:0] EXT_REQ_ENABLE_OFF   = 8'h04;
	localparam logic [WB_ADDR_W-1:0] EXT_REQ_FLAGS_OFF    = 8'h08;
	localparam logic [WB_ADDR_W-1:0] AUTO_XFER_SELECT_OFF = 8'h0C;
	localparam logic [WB_ADDR_W-1:0] WAKE_ENABLE_CTRL_OFF = 8'h10;
	localparam logic [WB_ADDR_W-1:0] WAKE_FLAG_REG_OFF    = 8'h14;
	localparam logic [WB_ADDR_W-1:0] DELAYED_REQ_REG_OFF  = 8'h18;
	localparam logic [WB_ADDR_W-1:0] IRQ_STATUS_OFF       = 8'h1C;
	localparam logic [WB_ADDR_W-1:0] IRQ_MASK_OFF         = 8'h20;
	localparam logic [WB_ADDR_W-1:0] XFER_DONE_OFF        = 8'h24;

	// Field positions.
	localparam int WAKE_FLAG_POS = 0;
	localparam int DELAYED_REQ_BIT_POS = 0;
	localparam int EVT_EXT_POS = 0;
	localparam int EVT_WAKE_POS = 1;
	localparam int EVT_DELAYED_POS = 2;
	localparam int EVT_XFER_POS = 3;
	localparam int EVT_W = 4;

	// Reset values.
	localparam logic [15:0] DETECT_LEVEL_CFG_RST = 16'h0000;
	localparam logic [7:0] EXT_REQ_ENABLE_RST = 8'h00;
	localparam logic [7:0] AUTO_XFER_SELECT_RST = 8'h00;
	localparam logic [7:0] WAKE_ENABLE_CTRL_RST = 8'h00;
	localparam logic [EVT_W-1:0] IRQ_MASK_RST = 4'h0;

	// Edges after reset before the edge history holds a real pin sample.
	localparam logic [1:0] EDGE_FILL_CYCLES = 2'h3;

	// Detection condition codes, two bits per external channel.
	typedef enum logic [1:0] {
		EWS_DET_LOW = 2'h0,
		EWS_DET_HIGH = 2'h1,
		EWS_DET_RISE = 2'h2,
		EWS_DET_FALL = 2'h3
	} ews_det_t;

	typedef struct packed {
		logic [EXT_CHANNELS-1:0] ext_irq;
		logic [EXT_CHANNELS-1:0] xfer_req;
		logic                    wake_irq;
		logic                    wake_resume;
		logic                    delayed_irq;
	} ews_req_t;

endpackage : ews_pkg

// ---- verification/ews_ctrl_bench.sv ----
`timescale 1ns/1ps
module ews_ctrl_bench;
	import ews_pkg::*;
	logic        clock = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
	logic        stdby = 1'b0, hw = 1'b0, slow = 1'b1;
	logic [7:0]  adr = 8'h00, ext_lvl = 8'hF9, wake_n = 8'hFF, ext_pin, wake_pin, done;
	logic [31:0] wdat = 32'h0, rdat, got;
	ews_req_t    req;
	int          miscompares = 0, checks = 0, cycles = 0;
	always #2 clock = ~clock;
	ews_ctrl dut (.i_clock(clock), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_ext_req_in(ext_pin), .i_wake_in_n(wake_pin), .i_xfer_done(done), .i_standby(stdby),
		.i_hw_standby(hw), .o_req(req), .o_irq(irq));
	ews_pins_model pins (.i_clock(clock), .i_ext_lvl(ext_lvl), .i_wake_lvl_n(wake_n),
		.i_xfer_req(req.xfer_req), .i_slow(slow), .o_ext_req_in(ext_pin),
		.o_wake_in_n(wake_pin), .o_xfer_done(done));
	task automatic tally_and_finish();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic ticks(input int n);
		repeat (n) @(posedge clock);
	endtask : ticks
	// Classic single cycle; read data is taken at the edge where ack is sampled high.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clock); while (ack !== 1'b1);
		got = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clock);
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		check($sformatf("register %h", a), exp, got);
	endtask : rd
	task automatic reset_values();
		for (int i = 0; i < 10; i++) if (!(i inside {2, 5, 7})) rd(8'(4 * i), 32'h0);
		wb(1'b1, 8'h40, 32'hFF);
		rd(8'h40, 32'h0);
	endtask : reset_values
	task automatic ext_modes();
		wb(1'b1, DETECT_LEVEL_CFG_OFF, 32'hE4);
		wb(1'b1, EXT_REQ_FLAGS_OFF, 32'hFF);
		wb(1'b1, EXT_REQ_ENABLE_OFF, 32'h0F);
		wb(1'b1, IRQ_STATUS_OFF, 32'hF);
		wb(1'b1, IRQ_MASK_OFF, 32'h1);
		rd(EXT_REQ_FLAGS_OFF, 32'h0);
		check("irq", 32'h0, 32'(irq));
		ext_lvl <= 8'hE6;
		ticks(6);
		rd(EXT_REQ_FLAGS_OFF, 32'h1F);
		check("ext_irq", 32'h0F, 32'(req.ext_irq));
		check("irq", 32'h1, 32'(irq));
		wb(1'b1, EXT_REQ_FLAGS_OFF, 32'hFF);
		ticks(2);
		rd(EXT_REQ_FLAGS_OFF, 32'h13);
		wb(1'b1, IRQ_MASK_OFF, 32'h0);
		ticks(2);
		check("irq", 32'h0, 32'(irq));
		ext_lvl <= 8'hF9;
		ticks(4);
		wb(1'b1, EXT_REQ_FLAGS_OFF, 32'hFF);
		wb(1'b1, IRQ_STATUS_OFF, 32'hF);
		wb(1'b1, IRQ_MASK_OFF, 32'hF);
		ticks(2);
		check("irq", 32'h0, 32'(irq));
		rd(EXT_REQ_FLAGS_OFF, 32'h0);
	endtask : ext_modes
	task automatic auto_xfer();
		ext_lvl <= 8'hFF;
		ticks(5);
		check("ext_irq", 32'h06, 32'(req.ext_irq));
		check("xfer_req", 32'h0, 32'(req.xfer_req));
		wb(1'b1, EXT_REQ_FLAGS_OFF, 32'h06);
		wb(1'b1, AUTO_XFER_SELECT_OFF, 32'h06);
		ticks(3);
		check("xfer_req", 32'h06, 32'(req.xfer_req));
		check("ext_irq", 32'h0, 32'(req.ext_irq));
		for (int n = 0; n < 40 && req.ext_irq[2:1] !== 2'b11; n++) @(posedge clock);
		check("ext_irq", 32'h06, 32'(req.ext_irq));
		check("xfer_req", 32'h0, 32'(req.xfer_req));
		ext_lvl <= 8'hF9;
		ticks(4);
		wb(1'b1, AUTO_XFER_SELECT_OFF, 32'h0);
		wb(1'b1, EXT_REQ_FLAGS_OFF, 32'hFF);
	endtask : auto_xfer
	task automatic wakeup();
		wb(1'b1, WAKE_ENABLE_CTRL_OFF, 32'h81);
		stdby <= 1'b1;
		hw <= 1'b1;
		wake_n <= 8'hF7;
		ticks(6);
		rd(WAKE_FLAG_REG_OFF, 32'h0);
		wake_n <= 8'h76;
		ticks(6);
		rd(WAKE_FLAG_REG_OFF, 32'h1);
		check("wake_irq", 32'h1, 32'(req.wake_irq));
		check("wake_resume", 32'h0, 32'(req.wake_resume));
		check("xfer_req", 32'h0, 32'(req.xfer_req));
		hw <= 1'b0;
		ticks(3);
		check("wake_resume", 32'h1, 32'(req.wake_resume));
		wake_n <= 8'hFF;
		stdby <= 1'b0;
		ticks(4);
		wb(1'b1, WAKE_FLAG_REG_OFF, 32'h1);
		rd(WAKE_FLAG_REG_OFF, 32'h0);
	endtask : wakeup
	task automatic delayed();
		wb(1'b1, DELAYED_REQ_REG_OFF, 32'h1);
		ticks(1);
		check("delayed_irq", 32'h1, 32'(req.delayed_irq));
		rd(DELAYED_REQ_REG_OFF, 32'h1);
		rd(IRQ_STATUS_OFF, 32'hF);
		check("irq", 32'h1, 32'(irq));
		wb(1'b1, IRQ_STATUS_OFF, 32'hF);
		wb(1'b1, DELAYED_REQ_REG_OFF, 32'h0);
		ticks(1);
		check("delayed_irq", 32'h0, 32'(req.delayed_irq));
		rd(DELAYED_REQ_REG_OFF, 32'h0);
		rd(IRQ_STATUS_OFF, 32'h0);
	endtask : delayed
	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		reset_values();
		ext_modes();
		auto_xfer();
		wakeup();
		delayed();
		tally_and_finish();
	end
endmodule : ews_ctrl_bench

// ---- verification/ews_ctrl_sva.sv ----
`timescale 1ns/1ps
module ews_ctrl_sva
	import ews_pkg::*;
(
	input wire logic                            i_clock,
	input wire logic                            i_rst,
	input wire logic                            i_wb_cyc,
	input wire logic                            i_wb_stb,
	input wire logic                            i_wb_we,
	input wire logic [ews_pkg::WB_ADDR_W-1:0]   i_wb_adr,
	input wire logic [3:0]                      i_wb_sel,
	input wire logic [31:0]                     i_wb_dat,
	input wire logic [31:0]                     o_wb_dat,
	input wire logic                            o_wb_ack,
	input wire logic [ews_pkg::EXT_CHANNELS-1:0] i_xfer_done,
	input wire logic                            i_hw_standby,
	input wire ews_pkg::ews_req_t               o_req
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	ack_one_cycle_a: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	ack_response_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("bus request not answered next cycle");
	unmapped_read_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr > XFER_DONE_OFF
		|-> o_wb_dat == 32'h0) else $error("unmapped read not zero");
	delayed_write_a: assert property (
		o_wb_ack && i_wb_we && i_wb_sel[0] && i_wb_adr == DELAYED_REQ_REG_OFF
		|=> ##1 (o_req.delayed_irq == $past(i_wb_dat[0], 2))) else $error("delayed request wrong");
	hw_standby_a: assert property (i_hw_standby [*2] |=> !o_req.wake_resume)
		else $error("resume during hardware standby");
	resume_flag_a: assert property (o_req.wake_resume |-> o_req.wake_irq)
		else $error("resume without wake flag");
	service_exclusive_a: assert property ((o_req.ext_irq & o_req.xfer_req) == 8'h00)
		else $error("handler and transfer requested together");
	xfer_then_handler_a: assert property (i_xfer_done[1] && o_req.xfer_req[1]
		|-> ##[1:2] (o_req.ext_irq[1] && !o_req.xfer_req[1])) else $error("no handler after transfer");
endmodule : ews_ctrl_sva
bind ews_ctrl ews_ctrl_sva u_sva (.i_clock, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
	.i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_xfer_done, .i_hw_standby, .o_req);

// ---- verification/ews_pins_model.sv ----
`timescale 1ns/1ps
module ews_pins_model (
	input  wire logic       i_clock,
	input  wire logic [7:0] i_ext_lvl,
	input  wire logic [7:0] i_wake_lvl_n,
	input  wire logic [7:0] i_xfer_req,
	input  wire logic       i_slow,
	output logic      [7:0] o_ext_req_in,
	output logic      [7:0] o_wake_in_n,
	output logic      [7:0] o_xfer_done
);
	logic [3:0] wait_r = 4'h0;
	logic [7:0] done_r = 8'h00;
	assign o_ext_req_in = i_ext_lvl;
	assign o_wake_in_n  = i_wake_lvl_n;
	assign o_xfer_done  = done_r;
	// The transfer service finishes every pending channel at once, after a short or long wait.
	always_ff @(posedge i_clock) begin
		done_r <= 8'h00;
		if (i_xfer_req == 8'h00 || done_r != 8'h00) begin
			wait_r <= 4'h0;
		end else if (wait_r == (i_slow ? 4'h9 : 4'h1)) begin
			done_r <= i_xfer_req;
			wait_r <= 4'h0;
		end else begin
			wait_r <= wait_r + 4'h1;
		end
	end
endmodule : ews_pins_model
